// [bro_pkg.sv]
// Purpose: shared constants and types of the BCD result port
// Assumes: 200 MHz core clock, 32-bit Avalon-MM register slave
// Notes: all times are in milliseconds, converted to cycles in the top
package bro_pkg;
  localparam int CLK_HZ = 200000000;
  localparam int MS_PER_S = 1000;
  localparam int T_SET_MS = 30;
  localparam int T_VALID_MS = 40;
  localparam int T_OFF_MS = 16;
  localparam int T_PERIOD_MS = 64;
  localparam int T_SETTLE_MS = 1;
  localparam int TMR_W = 7;
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_SHIFT = 5'h04;
  localparam logic [ADDR_W-1:0] ADDR_HILIM = 5'h08;
  localparam logic [ADDR_W-1:0] ADDR_LOLIM = 5'h0c;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h10;
  localparam logic [ADDR_W-1:0] ADDR_RESULT = 5'h14;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MODE_W = 3;
  localparam int CTRL_STBY_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [15:0] SHIFT_RESET = 16'h0000;
  localparam logic [15:0] HILIM_RESET = 16'h7fff;
  localparam logic [15:0] LOLIM_RESET = 16'h8000;
  localparam int ST_VALID_BIT = 0;
  localparam int ST_HIGH_BIT = 1;
  localparam int ST_PASS_BIT = 2;
  localparam int ST_LOW_BIT = 3;
  localparam int ST_ARMED_BIT = 4;
  localparam int ST_FREEZE_BIT = 5;
  localparam int ST_OVER_BIT = 6;
  localparam int ST_STATE_LSB = 8;
  localparam int ST_LEVEL_LSB = 16;
  localparam int BCD_DIGITS = 4;
  localparam int BCD_BIN_W = 14;
  localparam logic [BCD_BIN_W-1:0] BCD_MAX = 14'h270f;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [2:0]
  {
    MODE_NORMAL = 3'b000,
    MODE_SAMPLE = 3'b001,
    MODE_PEAK = 3'b010,
    MODE_BOTTOM = 3'b011,
    MODE_P2P = 3'b100
  } bro_mode_type;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_SETTLE = 3'b010,
    ST_VALID = 3'b011,
    ST_WAIT = 3'b100,
    ST_TAIL = 3'b101
  } bro_state_type;
endpackage

// [bro_fifo.sv]
// Purpose: measurement buffer with valid/ready on both sides
// Assumes: single clock, synchronous active-high reset
// Notes: full and empty come from an occupancy count
`timescale 1ns/1ps
`default_nettype none
module bro_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic core_clk, // core clock
  input wire logic rst, // synchronous reset
  input wire logic inValid, // write side valid
  input wire logic [WIDTH-1:0] inData, // write side data
  output logic inReady, // not full
  output logic outValid, // not empty
  output logic [WIDTH-1:0] outData, // head word
  input wire logic outReady, // read side ready
  output logic [$clog2(DEPTH+1)-1:0] level // words held
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [CW-1:0] count_q;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] nextPtr(input logic [AW-1:0] p);
    return (p == AW'(DEPTH-1)) ? '0 : p + 1'b1;
  endfunction

  assign inReady = count_q != CW'(DEPTH);
  assign outValid = count_q != '0;
  assign push = inValid & inReady;
  assign pop = outValid & outReady;
  assign outData = mem[rdPtr_q];
  assign level = count_q;

  always_ff @(posedge core_clk)
  begin
    if (push)
    begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wrPtr_q <= nextPtr(wrPtr_q);
      end
      if (pop)
      begin
        rdPtr_q <= nextPtr(rdPtr_q);
      end
      if (push != pop)
      begin
        count_q <= push ? count_q + 1'b1 : count_q - 1'b1;
      end
    end
  end
endmodule // bro_fifo
`default_nettype wire

// [bro_result_port.sv]
// Purpose: BCD result port with hold modes, limits, standby and shift
// Assumes: pins are asynchronous and active high at this boundary
// Notes: Avalon-MM slave answers every access after one wait cycle
`timescale 1ns/1ps
`default_nettype none
module bro_result_port #(
  parameter int W = 16,
  parameter int MS_CYCLES = bro_pkg::CLK_HZ / bro_pkg::MS_PER_S
) (
  input wire logic core_clk, // core clock
  input wire logic rst, // synchronous reset
  input wire logic [bro_pkg::ADDR_W-1:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  input wire logic measValid, // new raw measurement
  input wire logic [W-1:0] measData, // signed raw measurement
  output logic measReady, // buffer can take a measurement
  input wire logic readReqPin, // read strobe pin
  input wire logic freezePin, // freeze pin
  input wire logic triggerPin, // capture trigger pin
  output logic [15:0] bcdData, // four BCD digits
  output logic bcdNegative, // sign of presented result
  output logic bcdOver, // magnitude above four digits
  output logic dataValid, // output qualifier
  output logic cmpHigh, // above high limit
  output logic cmpPass, // within limits
  output logic cmpLow // below low limit
);
  import bro_pkg::*;

  localparam int LW = $clog2(FIFO_DEPTH+1);

  logic [2:0] pinMeta_q;
  logic [2:0] pinSync_q;
  logic reqSync;
  logic freezeSync;
  logic trigSync;
  logic trigPrev_q;
  logic trigRise;
  logic ack_q;
  logic [3:0] ctrl_q;
  logic [15:0] shift_q;
  logic [15:0] hiLim_q;
  logic [15:0] loLim_q;
  logic [31:0] statusWord;
  logic fifoValid;
  logic [W-1:0] fifoData;
  logic [LW-1:0] fifoLevel;
  logic take;
  logic signed [W-1:0] shifted;
  logic signed [W-1:0] current_q;
  logic signed [W-1:0] sample_q;
  logic signed [W-1:0] max_q;
  logic signed [W-1:0] min_q;
  logic trackEmpty_q;
  logic signed [W-1:0] result;
  logic [W-1:0] magnitude;
  logic over;
  logic inHigh;
  logic inLow;
  logic armed_q;
  logic [31:0] divCnt_q;
  logic msTick;
  logic [TMR_W-1:0] tmr_q;
  logic tmrDone;
  bro_state_type state_q;
  bro_state_type state_d;
  bro_mode_type mode;

  function automatic logic signed [W-1:0] clampWide(
    input logic signed [W:0] v);
    logic signed [W-1:0] r;
    r = v[W-1:0];
    if (v[W] != v[W-1])
    begin
      r = v[W] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
    end
    return r;
  endfunction

  function automatic logic [15:0] toBcd(input logic [BCD_BIN_W-1:0] v);
    logic [BCD_BIN_W+15:0] s;
    s = {16'h0000, v};
    for (int i = 0; i < BCD_BIN_W; i++)
    begin
      for (int d = 0; d < BCD_DIGITS; d++)
      begin
        if (s[BCD_BIN_W+4*d +: 4] > 4'h4)
        begin
          s[BCD_BIN_W+4*d +: 4] = s[BCD_BIN_W+4*d +: 4] + 4'h3;
        end
      end
      s = s << 1;
    end
    return s[BCD_BIN_W +: 16];
  endfunction

  // pins cross from outside; only the second stage is read
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pinMeta_q <= 3'h0;
      pinSync_q <= 3'h0;
      trigPrev_q <= 1'b0;
    end
    else
    begin
      pinMeta_q <= {readReqPin, freezePin, triggerPin};
      pinSync_q <= pinMeta_q;
      trigPrev_q <= trigSync;
    end
  end

  assign reqSync = pinSync_q[2];
  assign freezeSync = pinSync_q[1];
  assign trigSync = pinSync_q[0];
  assign trigRise = trigSync & ~trigPrev_q;
  assign mode = bro_mode_type'(ctrl_q[CTRL_MODE_LSB +: CTRL_MODE_W]);

  // register slave: one wait cycle, data loaded in the first cycle
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ctrl_q <= CTRL_RESET;
      shift_q <= SHIFT_RESET;
      hiLim_q <= HILIM_RESET;
      loLim_q <= LOLIM_RESET;
    end
    else if (avs_write & ack_q)
    begin
      unique case (avs_address)
        ADDR_CTRL: ctrl_q <= avs_writedata[3:0];
        ADDR_SHIFT: shift_q <= avs_writedata[15:0];
        ADDR_HILIM: hiLim_q <= avs_writedata[15:0];
        ADDR_LOLIM: loLim_q <= avs_writedata[15:0];
        default: ;
      endcase
    end
  end

  always_comb
  begin
    statusWord = 32'h0000_0000;
    statusWord[ST_VALID_BIT] = dataValid;
    statusWord[ST_HIGH_BIT] = cmpHigh;
    statusWord[ST_PASS_BIT] = cmpPass;
    statusWord[ST_LOW_BIT] = cmpLow;
    statusWord[ST_ARMED_BIT] = armed_q;
    statusWord[ST_FREEZE_BIT] = freezeSync;
    statusWord[ST_OVER_BIT] = over;
    statusWord[ST_STATE_LSB +: 3] = state_q;
    statusWord[ST_LEVEL_LSB +: LW] = fifoLevel;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      avs_readdata <= 32'h0000_0000;
    end
    else if (avs_read & ~ack_q)
    begin
      unique case (avs_address)
        ADDR_CTRL: avs_readdata <= {28'h0000000, ctrl_q};
        ADDR_SHIFT: avs_readdata <= {16'h0000, shift_q};
        ADDR_HILIM: avs_readdata <= {16'h0000, hiLim_q};
        ADDR_LOLIM: avs_readdata <= {16'h0000, loLim_q};
        ADDR_STATUS: avs_readdata <= statusWord;
        ADDR_RESULT: avs_readdata <= 32'(unsigned'(result));
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // freeze stalls the drain, so measurements back up into the buffer
  bro_fifo #(
    .WIDTH(W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .inValid(measValid),
    .inData(measData),
    .inReady(measReady),
    .outValid(fifoValid),
    .outData(fifoData),
    .outReady(~freezeSync),
    .level(fifoLevel)
  );

  assign take = fifoValid & ~freezeSync;
  // saturate so a large offset cannot wrap the sign
  assign shifted = clampWide(W'(signed'(fifoData)) + W'(signed'(shift_q))
    + (W+1)'(0));

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      current_q <= '0;
    end
    else if (take)
    begin
      current_q <= shifted;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      sample_q <= '0;
    end
    else if (trigRise)
    begin
      sample_q <= current_q;
    end
  end

  // extremes restart at each trigger rise and follow while it is high
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      trackEmpty_q <= 1'b1;
      max_q <= '0;
      min_q <= '0;
    end
    else if (trigRise)
    begin
      trackEmpty_q <= 1'b1;
    end
    else if (take & trigSync)
    begin
      trackEmpty_q <= 1'b0;
      if (trackEmpty_q | (shifted > max_q))
      begin
        max_q <= shifted;
      end
      if (trackEmpty_q | (shifted < min_q))
      begin
        min_q <= shifted;
      end
    end
  end

  always_comb
  begin
    unique case (mode)
      MODE_SAMPLE: result = sample_q;
      MODE_PEAK: result = max_q;
      MODE_BOTTOM: result = min_q;
      MODE_P2P: result = clampWide((W+1)'(max_q) - (W+1)'(min_q));
      default: result = current_q;
    endcase
  end

  assign magnitude = result[W-1] ? W'(-result) : W'(result);
  assign over = magnitude > W'(BCD_MAX);
  assign inHigh = result > W'(signed'(hiLim_q));
  assign inLow = result < W'(signed'(loLim_q));

  // armed while standby is off, so enabling it starts a fresh wait
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      armed_q <= 1'b1;
    end
    else if (~ctrl_q[CTRL_STBY_BIT])
    begin
      armed_q <= 1'b1;
    end
    else if (~inHigh & ~inLow)
    begin
      armed_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cmpHigh <= 1'b0;
      cmpPass <= 1'b0;
      cmpLow <= 1'b0;
    end
    else if (ctrl_q[CTRL_STBY_BIT] & armed_q)
    begin
      cmpHigh <= 1'b0;
      cmpPass <= 1'b0;
      cmpLow <= 1'b0;
    end
    else
    begin
      cmpHigh <= inHigh;
      cmpPass <= ~inHigh & ~inLow;
      cmpLow <= inLow;
    end
  end

  // millisecond enable, restarted whenever the timer is loaded
  assign msTick = divCnt_q == 32'(MS_CYCLES - 1);

  always_ff @(posedge core_clk)
  begin
    if (rst || state_d != state_q || msTick)
    begin
      divCnt_q <= 32'h0000_0000;
    end
    else
    begin
      divCnt_q <= divCnt_q + 32'h0000_0001;
    end
  end

  assign tmrDone = msTick && tmr_q == TMR_W'(1);

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:
        if (reqSync)
        begin
          state_d = ST_SETUP;
        end
      ST_SETUP:
        if (tmrDone)
        begin
          state_d = ST_SETTLE;
        end
      ST_SETTLE:
        if (tmrDone)
        begin
          state_d = ST_VALID;
        end
      ST_VALID:
        if (tmrDone)
        begin
          state_d = reqSync ? ST_WAIT : ST_TAIL;
        end
      ST_WAIT:
        if (~reqSync)
        begin
          state_d = ST_TAIL;
        end
        else if (tmrDone)
        begin
          state_d = ST_SETTLE;
        end
      ST_TAIL:
        if (tmrDone)
        begin
          state_d = ST_IDLE;
        end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      tmr_q <= '0;
    end
    else if (state_d != state_q)
    begin
      unique case (state_d)
        ST_SETUP: tmr_q <= TMR_W'(T_SET_MS - T_SETTLE_MS);
        ST_SETTLE: tmr_q <= TMR_W'(T_SETTLE_MS);
        ST_VALID: tmr_q <= TMR_W'(T_VALID_MS);
        ST_WAIT: tmr_q <= TMR_W'(T_PERIOD_MS - T_VALID_MS - T_SETTLE_MS);
        ST_TAIL: tmr_q <= TMR_W'(T_OFF_MS);
        default: tmr_q <= '0;
      endcase
    end
    else if (msTick && tmr_q != '0)
    begin
      tmr_q <= tmr_q - 1'b1;
    end
  end

  // data words load whole, so a freeze shows old or new until the return to idle clears them to zero
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      bcdData <= 16'h0000;
      bcdNegative <= 1'b0;
      bcdOver <= 1'b0;
    end
    else if (state_d == ST_SETTLE && state_q != ST_SETTLE)
    begin
      bcdData <= over ? toBcd(BCD_MAX) : toBcd(magnitude[BCD_BIN_W-1:0]);
      bcdNegative <= result[W-1];
      bcdOver <= over;
    end
    else if (state_d == ST_IDLE)
    begin
      bcdData <= 16'h0000;
      bcdNegative <= 1'b0;
      bcdOver <= 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      dataValid <= 1'b0;
    end
    else
    begin
      dataValid <= state_d == ST_VALID;
    end
  end
endmodule // bro_result_port
`default_nettype wire

// [bro_result_port_assertions.sv]
// Purpose: timing checks on the BCD result pins
// Assumes: MS_CYCLES equals that of the bound port
// Notes: counters stand in for the long millisecond spans
`timescale 1ns/1ps
`default_nettype none
module bro_result_port_assertions #(
  parameter int MS_CYCLES = 20
) (
  input wire logic core_clk, // clock
  input wire logic rst, // reset
  input wire logic readReqPin, // strobe
  input wire logic dataValid, // qualifier
  input wire logic [15:0] bcdData, // digits
  input wire logic cmpHigh, // above
  input wire logic cmpPass, // within
  input wire logic cmpLow // below
);
  localparam int M = MS_CYCLES;
  int reqCnt, hiCnt, loCnt, gapCnt;
  logic reqQ, validQ, first, tailReq;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  always_ff @(posedge core_clk)
  begin
    reqQ <= readReqPin;
    validQ <= dataValid;
    reqCnt <= rst ? 0 : (readReqPin && !reqQ) ? 1 : reqCnt + 1;
    gapCnt <= rst ? 0 : (dataValid && !validQ) ? 1 : gapCnt + 1;
    hiCnt <= (rst || !dataValid) ? 0 : hiCnt + 1;
  end
  always_ff @(posedge core_clk)
  begin
    if (rst || dataValid)
      loCnt <= 0;
    else if (loCnt < 20 * M)
      loCnt <= loCnt + 1;
  end
  // first marks the opening result of a request, later ones are periodic
  always_ff @(posedge core_clk)
  begin
    if (rst)
      first <= 1'b0;
    else if (readReqPin && !reqQ)
      first <= 1'b1;
    else if (dataValid && !validQ)
      first <= 1'b0;
    if (rst)
      tailReq <= 1'b0;
    else if (dataValid)
      tailReq <= readReqPin;
  end
  setup_time_a: assert property ($rose(dataValid) && first |->
    reqCnt >= 30 * M && reqCnt <= 30 * M + 6) else $error("setup off");
  data_first_a: assert property ($rose(dataValid) |->
    bcdData == $past(bcdData, 8)) else $error("data late");
  valid_width_a: assert property ($fell(dataValid) |->
    hiCnt >= 40 * M - 1 && hiCnt <= 40 * M + 1) else $error("width off");
  result_period_a: assert property ($rose(dataValid) && !first |->
    gapCnt >= 64 * M - 2 && gapCnt <= 64 * M + 2) else $error("period off");
  valid_stable_a: assert property (dataValid && $past(dataValid) |->
    $stable(bcdData)) else $error("data moved");
  data_hold_a: assert property (loCnt > 0 && loCnt < 16 * M - 2 |->
    $stable(bcdData)) else $error("data dropped early");
  data_release_a: assert property (loCnt == 16 * M + 4 && !tailReq |->
    bcdData == 16'h0000) else $error("data not released");
  limit_excl_a: assert property (
    $onehot0({cmpHigh, cmpPass, cmpLow})) else $error("limits clash");
  cover property ($rose(dataValid) && !first);
  cover property ($fell(dataValid) && !tailReq);
  cover property ($rose(cmpPass));
endmodule // bro_result_port_assertions
bind bro_result_port bro_result_port_assertions #(.MS_CYCLES(MS_CYCLES))
  bro_result_port_assertions_inst (.core_clk(core_clk), .rst(rst),
  .readReqPin(readReqPin), .dataValid(dataValid), .bcdData(bcdData),
  .cmpHigh(cmpHigh), .cmpPass(cmpPass), .cmpLow(cmpLow));
`default_nettype wire

// [bro_reader_model.sv]
// Purpose: reading controller on the far side of the BCD pins
// Assumes: MS clocks make one millisecond
// Notes: keep held high asks for continuous output
`timescale 1ns/1ps
`default_nettype none
module bro_reader_model #(
  parameter int MS = 20
) (
  input wire logic core_clk, // clock
  input wire logic rst, // reset
  input wire logic start, // read wanted
  input wire logic keep, // hold strobe
  input wire logic [7:0] lagMs, // extra wait
  input wire logic dataValid, // qualifier
  input wire logic [15:0] bcdData, // digits
  output logic readReqPin, // strobe
  output logic [15:0] gotData, // digits taken
  output int gotCount // results taken
);
  int quietCnt, stepCnt;
  logic pend, validQ;
  always_ff @(posedge core_clk)
  begin
    quietCnt <= (rst || dataValid) ? 0 : quietCnt + 1;
  end
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pend <= 1'b0;
      readReqPin <= 1'b0;
      stepCnt <= 0;
    end
    else if (start)
    begin
      pend <= 1'b1;
      stepCnt <= 0;
    end
    else if (pend)
    begin
      stepCnt <= stepCnt + 1;
      if (quietCnt >= 20 * MS && stepCnt >= lagMs * MS)
      begin
        readReqPin <= 1'b1;
        pend <= 1'b0;
        stepCnt <= 0;
      end
    end
    else if (readReqPin)
    begin
      stepCnt <= stepCnt + 1;
      if (!keep && stepCnt >= 5 * MS)
        readReqPin <= 1'b0;
    end
  end
  always_ff @(posedge core_clk)
  begin
    validQ <= dataValid;
    if (rst)
      gotCount <= 0;
    else if (dataValid && !validQ)
    begin
      gotData <= bcdData;
      gotCount <= gotCount + 1;
    end
  end
endmodule // bro_reader_model
`default_nettype wire

// [bro_result_port_tb.sv]
// Purpose: self-checking bench of the BCD result port
// Assumes: MS_CYCLES of 20, one ms is 20 clocks
// Notes: hold results are read back over the register bus
`timescale 1ns/1ps
`default_nettype none
module bro_result_port_tb;
  import bro_pkg::*;
  localparam int M = 20;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] adr = '0;
  logic rd = 1'b0, wr = 1'b0, mValid = 1'b0, frz = 1'b0, trig = 1'b0;
  logic start = 1'b0, keep = 1'b0;
  logic [31:0] wdat = '0, rdat;
  logic [15:0] mData = '0, bcd, gotData;
  logic [7:0] lag = 8'h03;
  logic wreq, mReady, req, neg, over, dv, hi, pass, lo;
  int gotCount, errCount = 0, samplesChecked = 0;
  logic [ADDR_W-1:0] regAdr [5] = '{ADDR_CTRL, ADDR_SHIFT, ADDR_HILIM,
    ADDR_LOLIM, 5'h18};
  logic [31:0] regDef [5] = '{32'h0, 32'h0, 32'h7fff, 32'h8000, 32'h0};
  logic [31:0] holdExp [6] = '{32'ha, 32'h7, 32'h1e, 32'h8, 32'h15,
    32'ha};
  logic [15:0] stbyIn [4] = '{16'hc8, 16'h46, 16'hc8, 16'h14};
  logic [2:0] stbyExp [4] = '{3'h0, 3'h2, 3'h4, 3'h1};
  initial forever #2.5 core_clk = ~core_clk;
  bro_result_port #(.MS_CYCLES(M)) bro_result_port_inst (
    .core_clk(core_clk), .rst(rst), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdat), .avs_readdata(rdat),
    .avs_waitrequest(wreq), .measValid(mValid), .measData(mData),
    .measReady(mReady), .readReqPin(req), .freezePin(frz),
    .triggerPin(trig), .bcdData(bcd), .bcdNegative(neg), .bcdOver(over),
    .dataValid(dv), .cmpHigh(hi), .cmpPass(pass), .cmpLow(lo));
  bro_reader_model #(.MS(M)) bro_reader_model_inst (
    .core_clk(core_clk), .rst(rst), .start(start), .keep(keep),
    .lagMs(lag), .dataValid(dv), .bcdData(bcd), .readReqPin(req),
    .gotData(gotData), .gotCount(gotCount));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp)
    begin
      errCount++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // request stands until waitrequest is seen low at a rising edge;
  // only the watchdog ends a wait that never finishes
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a,
    input logic [31:0] d, output logic [31:0] q);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= ~w;
    @(posedge core_clk);
    while (wreq !== 1'b0)
    begin
      @(posedge core_clk);
    end
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    wt(1);
  endtask
  task automatic push(input logic [15:0] v);
    logic ok;
    mValid <= 1'b1;
    mData <= v;
    do
    begin
      @(negedge core_clk);
      ok = mReady;
      @(posedge core_clk);
    end while (ok !== 1'b1);
    mValid <= 1'b0;
    wt(8);
  endtask
  task automatic waitGot(input int k);
    int n;
    n = 0;
    while (gotCount < k && n < 200 * M)
    begin
      wt(1);
      n++;
    end
    if (gotCount < k)
    begin
      errCount++;
      $display("[ERR] %0t no result reached the reader", $time);
      finalReport;
    end
  endtask
  task automatic finalReport;
    $display("compared %0d mismatched %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    logic [31:0] q;
    wt(6);
    rst <= 1'b0;
    wt(2);
    for (int i = 0; i < 5; i++)
    begin
      bus(1'b0, regAdr[i], 32'h0, q);
      chk(q, regDef[i]);
    end
    $display("test 1 done");
    bus(1'b1, ADDR_SHIFT, 32'hffe9, q);
    push(16'h007b);
    bus(1'b0, ADDR_RESULT, 32'h0, q);
    chk(q, 32'h64);
    chk({16'h0, bcd}, 32'h0);
    chk({29'h0, hi, pass, lo}, 32'h2);
    start <= 1'b1;
    wt(1);
    start <= 1'b0;
    waitGot(1);
    chk({16'h0, gotData}, 32'h0100);
    chk({30'h0, neg, over}, 32'h0);
    wt(60 * M);
    chk({16'h0, bcd}, 32'h0);
    $display("test 2 done");
    lag <= 8'h00;
    keep <= 1'b1;
    start <= 1'b1;
    wt(1);
    start <= 1'b0;
    waitGot(2);
    chk({16'h0, gotData}, 32'h0100);
    push(16'h01df);
    waitGot(3);
    chk({16'h0, gotData}, 32'h0456);
    frz <= 1'b1;
    wt(4);
    push(16'h032c);
    waitGot(4);
    chk({16'h0, gotData}, 32'h0456);
    chk(gotCount, 32'h4);
    frz <= 1'b0;
    keep <= 1'b0;
    wt(100 * M);
    $display("test 3 done");
    // freeze stalls the drain, so the buffer must fill and refuse
    frz <= 1'b1;
    mValid <= 1'b1;
    wt(FIFO_DEPTH + 6);
    @(negedge core_clk);
    chk({31'h0, mReady}, 32'h0);
    @(posedge core_clk);
    mValid <= 1'b0;
    bus(1'b0, ADDR_STATUS, 32'h0, q);
    chk({27'h0, q[20:16]}, 32'h10);
    frz <= 1'b0;
    wt(FIFO_DEPTH + 10);
    bus(1'b0, ADDR_STATUS, 32'h0, q);
    chk({27'h0, q[20:16]}, 32'h0);
    $display("test 4 done");
    bus(1'b1, ADDR_SHIFT, 32'h0, q);
    // first value under the trigger differs per mode so stale extremes would show
    for (int m = 0; m < 6; m++)
    begin
      bus(1'b1, ADDR_CTRL, 32'(m), q);
      push(16'h7);
      trig <= 1'b1;
      wt(8);
      push(16'(5 + m));
      push(16'h1e);
      push(16'ha);
      trig <= 1'b0;
      wt(8);
      bus(1'b0, ADDR_RESULT, 32'h0, q);
      chk(q, holdExp[m]);
    end
    $display("test 5 done");
    bus(1'b1, ADDR_HILIM, 32'h64, q);
    bus(1'b1, ADDR_LOLIM, 32'h32, q);
    bus(1'b1, ADDR_CTRL, 32'h8, q);
    for (int i = 0; i < 4; i++)
    begin
      push(stbyIn[i]);
      chk({29'h0, hi, pass, lo}, {29'h0, stbyExp[i]});
    end
    $display("test 6 done");
    push(16'hd8f0);
    start <= 1'b1;
    wt(1);
    start <= 1'b0;
    waitGot(5);
    chk({16'h0, gotData}, 32'h9999);
    chk({30'h0, neg, over}, 32'h3);
    $display("test 7 done");
    finalReport;
  end
  initial
  begin
    #200000;
    errCount++;
    $display("[ERR] %0t watchdog expired", $time);
    finalReport;
  end
endmodule // bro_result_port_tb
`default_nettype wire
